//--- rtl/hcc_top.sv
// heating/cooling mode and change-over logic of a room temperature controller
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "hcc_defines.svh"

// Overview of operation
// - one or two command values per level setting
// - heat/cool messages follow basic level only
// - mixed automatic: inside deadband both values zero
// - automatic: above cooling setpoint selects cooling
// - automatic: below lower deadband edge selects heating
// - change-over object: 1 heating, 0 cooling
// - mode-change sending only on real transitions
// - value-change sending transmits current or last mode
// - inside deadband object holds last mode
// - nonzero cycle factor resends object periodically
// - object control takes mode from object only
// - reset clears change-over object to zero
// - startup mode activated right after initialisation
// - object control: startup mode until object update
// - absolute setpoints force object control
module hcc_top
    import hcc_pkg::*;
#(
    parameter int CYC_BASE_CYCLES = `HCC_CYC_BASE_MS * 1000000 / `HCC_CLK_PERIOD_NS
)
(
    // clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic CE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // nonvolatile mode storage
    input wire logic NV_MODE_IN,
    output logic NV_WE,
    output logic NV_DATA,
    // command values and indications
    output hcc_cmd_t CMD_OUT,
    output logic HEAT_MSG,
    output logic COOL_MSG,
    // change-over telegram
    output logic TX_VALID,
    output logic TX_VALUE
);

    localparam hcc_state_t ST_RST = '{
        fsm: ST_INIT,
        cfg: hcc_cfg_t'(`HCC_CTRL_RST),
        cycle_factor: `HCC_CYCLE_RST,
        temp: `HCC_TEMP_RST,
        heat_sp: `HCC_HEAT_SP_RST,
        cool_sp: `HCC_COOL_SP_RST,
        dem: hcc_dem_t'(`HCC_DEM_RST),
        heating: `HCC_CO_COOL,
        co_obj: `HCC_CO_COOL,
        cmd: '0,
        heat_msg: 1'b0,
        cool_msg: 1'b0,
        tx_valid: 1'b0,
        tx_value: 1'b0,
        nv_we: 1'b0,
        nv_data: 1'b0,
        prdata: 32'h0
    };

    hcc_state_t st;
    hcc_state_t next_st;
    logic cyc_tick;
    logic mixed, auto_co, above, below, in_band;
    logic acc, wr, mapped, obj_upd;
    logic [31:0] rd_mux;

    // mode decode and temperature comparison against the deadband edges
    assign mixed = (st.cfg.op_mode == `HCC_OPM_MIXED);
    assign auto_co = mixed && !st.cfg.obj_ctrl && !st.cfg.abs_sp;
    assign above = $signed(st.temp) > $signed(st.cool_sp);
    assign below = $signed(st.temp) < $signed(st.heat_sp);
    assign in_band = !above && !below;

    // apb decode; zero wait states
    assign acc = PSEL && PENABLE;
    assign wr = acc && PWRITE;
    assign obj_upd = wr && (PADDR == `HCC_ADDR_COOBJ);
    always_comb
    begin
        mapped = 1'b1;
        rd_mux = 32'h0;
        unique case (PADDR)
            `HCC_ADDR_CTRL:
            begin
                rd_mux[`HCC_CTRL_OPM_POS +: 2] = st.cfg.op_mode;
                rd_mux[`HCC_CTRL_ADD_POS] = st.cfg.add_en;
                rd_mux[`HCC_CTRL_OBJ_POS] = st.cfg.obj_ctrl;
                rd_mux[`HCC_CTRL_SEND_POS] = st.cfg.send_on_cmd;
                rd_mux[`HCC_CTRL_START_POS +: 2] = st.cfg.startup;
                rd_mux[`HCC_CTRL_ABS_POS] = st.cfg.abs_sp;
            end
            `HCC_ADDR_CYCLE: rd_mux[7:0] = st.cycle_factor;
            `HCC_ADDR_TEMP: rd_mux[15:0] = st.temp;
            `HCC_ADDR_SETP:
            begin
                rd_mux[`HCC_SETP_HEAT_POS +: 16] = st.heat_sp;
                rd_mux[`HCC_SETP_COOL_POS +: 16] = st.cool_sp;
            end
            `HCC_ADDR_DEMAND:
            begin
                rd_mux[`HCC_DEM_BASIC_POS +: 8] = st.dem.basic;
                rd_mux[`HCC_DEM_ADD_POS +: 8] = st.dem.add;
            end
            `HCC_ADDR_COOBJ: rd_mux[0] = st.co_obj;
            `HCC_ADDR_STATUS:
            begin
                rd_mux[`HCC_STAT_HEATING_POS] = st.heating;
                rd_mux[`HCC_STAT_HMSG_POS] = st.heat_msg;
                rd_mux[`HCC_STAT_CMSG_POS] = st.cool_msg;
                rd_mux[`HCC_STAT_OBJ_POS] = st.co_obj;
                rd_mux[`HCC_STAT_BAND_POS] = in_band;
                rd_mux[`HCC_STAT_RUN_POS] = (st.fsm == ST_RUN);
            end
            default: mapped = 1'b0;
        endcase
    end

    // next state: registers, mode selection, command gating, telegrams
    always_comb
    begin
        next_st = st;
        next_st.tx_valid = 1'b0;
        next_st.nv_we = 1'b0;
        if (PSEL && !PENABLE)
            next_st.prdata = rd_mux;
        if (wr)
        begin
            unique case (PADDR)
                `HCC_ADDR_CTRL:
                begin
                    next_st.cfg.op_mode = PWDATA[`HCC_CTRL_OPM_POS +: 2];
                    next_st.cfg.add_en = PWDATA[`HCC_CTRL_ADD_POS];
                    next_st.cfg.obj_ctrl = PWDATA[`HCC_CTRL_OBJ_POS];
                    next_st.cfg.send_on_cmd = PWDATA[`HCC_CTRL_SEND_POS];
                    next_st.cfg.startup = PWDATA[`HCC_CTRL_START_POS +: 2];
                    next_st.cfg.abs_sp = PWDATA[`HCC_CTRL_ABS_POS];
                end
                `HCC_ADDR_CYCLE: next_st.cycle_factor = PWDATA[7:0];
                `HCC_ADDR_TEMP: next_st.temp = PWDATA[15:0];
                `HCC_ADDR_SETP:
                begin
                    next_st.heat_sp = PWDATA[`HCC_SETP_HEAT_POS +: 16];
                    next_st.cool_sp = PWDATA[`HCC_SETP_COOL_POS +: 16];
                end
                `HCC_ADDR_DEMAND:
                begin
                    next_st.dem.basic = PWDATA[`HCC_DEM_BASIC_POS +: 8];
                    next_st.dem.add = PWDATA[`HCC_DEM_ADD_POS +: 8];
                end
                `HCC_ADDR_COOBJ: next_st.co_obj = PWDATA[0];
                default: next_st.co_obj = next_st.co_obj;
            endcase
        end
        unique case (st.fsm)
            ST_INIT:
            begin
                // initialisation ends with the configuration write; object keeps zero
                if (wr && (PADDR == `HCC_ADDR_CTRL))
                begin
                    unique case (next_st.cfg.startup)
                        `HCC_START_HEAT: next_st.heating = `HCC_CO_HEAT;
                        `HCC_START_PREV: next_st.heating = NV_MODE_IN;
                        default: next_st.heating = `HCC_CO_COOL;
                    endcase
                    next_st.fsm = ST_RUN;
                end
            end
            ST_RUN:
            begin
                // mode selection per operating mode and change-over source
                if (st.cfg.op_mode == `HCC_OPM_HEAT)
                    next_st.heating = `HCC_CO_HEAT;
                else if (st.cfg.op_mode == `HCC_OPM_COOL)
                    next_st.heating = `HCC_CO_COOL;
                else if (auto_co)
                begin
                    if (above)
                        next_st.heating = `HCC_CO_COOL;
                    else if (below)
                        next_st.heating = `HCC_CO_HEAT;
                end
                else if (obj_upd)
                begin
                    next_st.heating = PWDATA[0];
                end
                // restore-previous keeps storage in step with the mode
                if (st.cfg.startup == `HCC_START_PREV && next_st.heating != st.heating)
                begin
                    next_st.nv_we = 1'b1;
                    next_st.nv_data = next_st.heating;
                end
            end
        endcase
        // command gating; deadband in automatic mixed mode forces zero
        next_st.cmd = '0;
        if (st.fsm == ST_RUN && !(auto_co && in_band))
        begin
            if (next_st.heating)
            begin
                next_st.cmd.heat_basic = st.dem.basic;
                next_st.cmd.heat_add = st.cfg.add_en ? st.dem.add : 8'h00;
            end
            else
            begin
                next_st.cmd.cool_basic = st.dem.basic;
                next_st.cmd.cool_add = st.cfg.add_en ? st.dem.add : 8'h00;
            end
        end
        // indications from the basic level only
        next_st.heat_msg = next_st.heating && next_st.cmd.heat_basic != 8'h00;
        next_st.cool_msg = !next_st.heating && next_st.cmd.cool_basic != 8'h00;
        // change-over telegrams in automatic mode only
        if (st.fsm == ST_RUN && auto_co)
        begin
            if (!st.cfg.send_on_cmd && next_st.heating != st.heating)
            begin
                next_st.tx_valid = 1'b1;
            end
            if (st.cfg.send_on_cmd
                && (next_st.cmd.heat_basic | next_st.cmd.cool_basic)
                != (st.cmd.heat_basic | st.cmd.cool_basic))
            begin
                next_st.tx_valid = 1'b1;
            end
            if (cyc_tick)
            begin
                next_st.tx_valid = 1'b1;
            end
            if (next_st.tx_valid || next_st.heating != st.heating)
            begin
                next_st.tx_value = next_st.heating;
                next_st.co_obj = next_st.heating;
            end
        end
    end

    // state register; reset clears the object to zero
    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            st <= ST_RST;
        end
        else if (CE)
        begin
            st <= next_st;
        end
    end

    // cyclic resend timer
    hcc_cycle #(
        .BASE_CYCLES(CYC_BASE_CYCLES)
    ) u_cycle (
        .clk(SYS_CLK),
        .srst(SRST),
        .ce(CE),
        .enable(auto_co && st.fsm == ST_RUN),
        .factor(st.cycle_factor),
        .tick(cyc_tick)
    );

    // outputs
    assign PRDATA = st.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = acc && !mapped;
    assign NV_WE = st.nv_we;
    assign NV_DATA = st.nv_data;
    assign CMD_OUT = st.cmd;
    assign HEAT_MSG = st.heat_msg;
    assign COOL_MSG = st.cool_msg;
    assign TX_VALID = st.tx_valid;
    assign TX_VALUE = st.tx_value;

    // checks
    sequence s_init_step;
        CE && st.fsm == ST_INIT;
    endsequence

    sequence s_auto_run;
        CE && st.fsm == ST_RUN && auto_co;
    endsequence

    property p_band_zero;
        @(posedge SYS_CLK) disable iff (SRST)
        s_auto_run and in_band |=> CMD_OUT == '0;
    endproperty
    a_band_zero: assert property (p_band_zero) else $error("deadband output not zero");

    property p_hot_cools;
        @(posedge SYS_CLK) disable iff (SRST)
        s_auto_run and above |=> !st.heating;
    endproperty
    a_hot_cools: assert property (p_hot_cools) else $error("no cooling above setpoint");

    property p_cold_heats;
        @(posedge SYS_CLK) disable iff (SRST)
        s_auto_run and below |=> st.heating;
    endproperty
    a_cold_heats: assert property (p_cold_heats) else $error("no heating below edge");

    property p_mode_tx;
        @(posedge SYS_CLK) disable iff (SRST)
        s_auto_run and !st.cfg.send_on_cmd and next_st.heating != st.heating
            |=> TX_VALID && TX_VALUE == st.heating && TX_VALUE != $past(st.heating);
    endproperty
    a_mode_tx: assert property (p_mode_tx) else $error("transition not sent");

    property p_tx_only_auto;
        @(posedge SYS_CLK) disable iff (SRST)
        TX_VALID |-> $past(auto_co) && TX_VALUE == st.co_obj;
    endproperty
    a_tx_only_auto: assert property (p_tx_only_auto) else $error("telegram outside auto");

    property p_obj_ctrl;
        @(posedge SYS_CLK) disable iff (SRST)
        CE && st.fsm == ST_RUN && mixed && !auto_co && !obj_upd |=> $stable(st.heating);
    endproperty
    a_obj_ctrl: assert property (p_obj_ctrl) else $error("mode moved without object");

    property p_reset_obj;
        @(posedge SYS_CLK)
        SRST |=> !st.co_obj && st.fsm == ST_INIT;
    endproperty
    a_reset_obj: assert property (p_reset_obj) else $error("object not zero at reset");

    property p_startup;
        @(posedge SYS_CLK) disable iff (SRST)
        s_init_step and wr && PADDR == `HCC_ADDR_CTRL
            && PWDATA[`HCC_CTRL_START_POS +: 2] == `HCC_START_HEAT |=> st.heating && st.fsm == ST_RUN;
    endproperty
    a_startup: assert property (p_startup) else $error("startup mode not taken");

    property p_nv_write;
        @(posedge SYS_CLK) disable iff (SRST)
        CE && st.fsm == ST_RUN && st.cfg.startup == `HCC_START_PREV
            && next_st.heating != st.heating |=> NV_WE && NV_DATA == st.heating;
    endproperty
    a_nv_write: assert property (p_nv_write) else $error("mode not stored");

    property p_msg;
        @(posedge SYS_CLK) disable iff (SRST)
        HEAT_MSG |-> st.heating && CMD_OUT.heat_basic != 8'h00 && !COOL_MSG;
    endproperty
    a_msg: assert property (p_msg) else $error("heat message without basic level");

    property p_single_add;
        @(posedge SYS_CLK) disable iff (SRST)
        CE && !mixed && !st.cfg.add_en |=> CMD_OUT.heat_add == 8'h00 && CMD_OUT.cool_add == 8'h00;
    endproperty
    a_single_add: assert property (p_single_add) else $error("additional level active");

endmodule : hcc_top

//--- pkg/hcc_defines.svh
// register offsets, field positions, reset values and timing of the change-over block
`ifndef HCC_DEFINES_SVH
`define HCC_DEFINES_SVH

// register byte offsets
`define HCC_ADDR_CTRL 8'h00
`define HCC_ADDR_CYCLE 8'h04
`define HCC_ADDR_TEMP 8'h08
`define HCC_ADDR_SETP 8'h0C
`define HCC_ADDR_DEMAND 8'h10
`define HCC_ADDR_COOBJ 8'h14
`define HCC_ADDR_STATUS 8'h18

// control field positions
`define HCC_CTRL_OPM_POS 0
`define HCC_CTRL_ADD_POS 2
`define HCC_CTRL_OBJ_POS 3
`define HCC_CTRL_SEND_POS 4
`define HCC_CTRL_START_POS 5
`define HCC_CTRL_ABS_POS 7

// setpoint and demand field positions
`define HCC_SETP_HEAT_POS 0
`define HCC_SETP_COOL_POS 16
`define HCC_DEM_BASIC_POS 0
`define HCC_DEM_ADD_POS 8

// status field positions
`define HCC_STAT_HEATING_POS 0
`define HCC_STAT_HMSG_POS 1
`define HCC_STAT_CMSG_POS 2
`define HCC_STAT_OBJ_POS 3
`define HCC_STAT_BAND_POS 4
`define HCC_STAT_RUN_POS 5

// operating mode and startup mode codes
`define HCC_OPM_HEAT 2'h0
`define HCC_OPM_COOL 2'h1
`define HCC_OPM_MIXED 2'h2
`define HCC_START_HEAT 2'h0
`define HCC_START_COOL 2'h1
`define HCC_START_PREV 2'h2

// change-over object polarity
`define HCC_CO_HEAT 1'b1
`define HCC_CO_COOL 1'b0

// reset values
`define HCC_CTRL_RST 8'h00
`define HCC_CYCLE_RST 8'h00
`define HCC_TEMP_RST 16'h0000
`define HCC_HEAT_SP_RST 16'h0000
`define HCC_COOL_SP_RST 16'h0000
`define HCC_DEM_RST 16'h0000

// timing: clock period and unit of the cycle factor
`define HCC_CLK_PERIOD_NS 100
`define HCC_CYC_BASE_MS 1000

`endif

//--- pkg/hcc_pkg.sv
// types shared by the change-over block
package hcc_pkg;

    typedef enum logic {ST_INIT, ST_RUN} hcc_fsm_t;

    typedef struct packed {
        logic [7:0] heat_basic;
        logic [7:0] heat_add;
        logic [7:0] cool_basic;
        logic [7:0] cool_add;
    } hcc_cmd_t;

    typedef struct packed {
        logic [7:0] basic;
        logic [7:0] add;
    } hcc_dem_t;

    typedef struct packed {
        logic [1:0] op_mode;
        logic add_en;
        logic obj_ctrl;
        logic send_on_cmd;
        logic [1:0] startup;
        logic abs_sp;
    } hcc_cfg_t;

    typedef struct packed {
        hcc_fsm_t fsm;
        hcc_cfg_t cfg;
        logic [7:0] cycle_factor;
        logic [15:0] temp;
        logic [15:0] heat_sp;
        logic [15:0] cool_sp;
        hcc_dem_t dem;
        logic heating;
        logic co_obj;
        hcc_cmd_t cmd;
        logic heat_msg;
        logic cool_msg;
        logic tx_valid;
        logic tx_value;
        logic nv_we;
        logic nv_data;
        logic [31:0] prdata;
    } hcc_state_t;

    typedef struct packed {
        logic [31:0] base_cnt;
        logic [7:0] fac_cnt;
        logic tick;
    } hcc_cyc_state_t;

endpackage : hcc_pkg

//--- rtl/hcc_cycle.sv
// periodic tick for cyclic resend of the change-over object
`timescale 1ns/1ns
module hcc_cycle
    import hcc_pkg::*;
#(
    parameter int BASE_CYCLES = 10
)
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // control
    input wire logic enable,
    input wire logic [7:0] factor,
    // result
    output logic tick
);

    hcc_cyc_state_t st;
    hcc_cyc_state_t next_st;

    // period is factor times the base count; zero factor or disable stops it
    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!enable || factor == 8'h00)
        begin
            next_st.base_cnt = 32'h0;
            next_st.fac_cnt = 8'h00;
        end
        else if (st.base_cnt == 32'(BASE_CYCLES - 1))
        begin
            next_st.base_cnt = 32'h0;
            if (st.fac_cnt == factor - 8'h01)
            begin
                next_st.fac_cnt = 8'h00;
                next_st.tick = 1'b1;
            end
            else
            begin
                next_st.fac_cnt = st.fac_cnt + 8'h01;
            end
        end
        else
        begin
            next_st.base_cnt = st.base_cnt + 32'h1;
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st <= '0;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule : hcc_cycle

//--- dv/hcc_bus_model.sv
// far-side model: change-over telegram receiver and nonvolatile mode cell
`timescale 1ns/1ns
module hcc_bus_model
#(
    parameter logic NV_INIT = 1'b0
)
(
    // clock
    input wire logic clk,
    // telegrams from the device
    input wire logic tx_valid,
    input wire logic tx_value,
    // nonvolatile mode cell
    input wire logic nv_we,
    input wire logic nv_data,
    output logic nv_mode_in
);
    int tx_cnt = 0;
    logic tx_last = 1'b0;
    int nv_cnt = 0;
    logic nv_val = NV_INIT;

    // record telegrams: 1 heating, 0 cooling
    always @(posedge clk)
    begin
        if (tx_valid === 1'b1)
        begin
            tx_cnt <= tx_cnt + 1;
            tx_last <= tx_value;
        end
        if (nv_we === 1'b1)
        begin
            nv_cnt <= nv_cnt + 1;
            nv_val <= nv_data;
        end
    end

    // stored mode offered back for the init cycle
    assign nv_mode_in = nv_val;
endmodule : hcc_bus_model

//--- dv/testbench.sv
// self-checking testbench of the change-over block
`timescale 1ns/1ns
`include "hcc_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module testbench;
    logic clk, srst, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, cmd_out, rdat;
    logic nv_mode_in, nv_we, nv_data, heat_msg, cool_msg, tx_valid, tx_value, rerr;
    int num_errors = 0;
    int comparisons = 0;
    int n0;

    // short cyclic period for simulation
    hcc_top #(.CYC_BASE_CYCLES(4)) dut_u (.SYS_CLK(clk), .SRST(srst), .CE(ce),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .NV_MODE_IN(nv_mode_in),
        .NV_WE(nv_we), .NV_DATA(nv_data), .CMD_OUT(cmd_out), .HEAT_MSG(heat_msg),
        .COOL_MSG(cool_msg), .TX_VALID(tx_valid), .TX_VALUE(tx_value));
    hcc_bus_model bus_u (.clk(clk), .tx_valid(tx_valid), .tx_value(tx_value),
        .nv_we(nv_we), .nv_data(nv_data), .nv_mode_in(nv_mode_in));

    // clock generator
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic stop_test;
        $display("counts: comparisons=%0d mismatches=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic do_reset;
        srst <= 1'b1;
        cyc(8);
        srst <= 1'b0;
        cyc(2);
    endtask : do_reset

    // one apb transfer, bounded wait for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            num_errors++;
            stop_test();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        cyc(2);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdat & m, e)
    endtask : rdchk

    task automatic t_reset;
        rdchk(`HCC_ADDR_COOBJ, 32'h1, 32'h0);
        rdchk(`HCC_ADDR_STATUS, 32'h21, 32'h00);
        rdchk(`HCC_ADDR_CTRL, 32'hFF, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        `CHK(rerr, 1'b1)
        $display("test reset done");
    endtask : t_reset

    task automatic t_single;
        wr(`HCC_ADDR_DEMAND, 32'h2040);
        wr(`HCC_ADDR_CTRL, 32'h0);
        `CHK(cmd_out, 32'h40000000)
        `CHK({heat_msg, cool_msg}, 2'h2)
        wr(`HCC_ADDR_CTRL, 32'h4);
        `CHK(cmd_out, 32'h40200000)
        wr(`HCC_ADDR_CTRL, 32'h5);
        `CHK(cmd_out, 32'h00004020)
        `CHK({heat_msg, cool_msg}, 2'h1)
        wr(`HCC_ADDR_DEMAND, 32'h2000);
        `CHK({heat_msg, cool_msg}, 2'h0)
        $display("test single done");
    endtask : t_single

    task automatic t_auto;
        wr(`HCC_ADDR_SETP, 32'h00DC00C8);
        wr(`HCC_ADDR_TEMP, 32'h00D0);
        wr(`HCC_ADDR_DEMAND, 32'h0040);
        wr(`HCC_ADDR_CTRL, 32'h40);
        wr(`HCC_ADDR_CTRL, 32'h42);
        `CHK(cmd_out, 32'h0)
        n0 = bus_u.tx_cnt;
        wr(`HCC_ADDR_TEMP, 32'h00F0);
        `CHK(bus_u.tx_cnt, n0 + 1)
        `CHK(bus_u.tx_last, 1'b0)
        `CHK(cmd_out, 32'h00004000)
        `CHK(bus_u.nv_val, 1'b0)
        rdchk(`HCC_ADDR_COOBJ, 32'h1, 32'h0);
        wr(`HCC_ADDR_TEMP, 32'h00DC);
        `CHK(cmd_out, 32'h0)
        rdchk(`HCC_ADDR_STATUS, 32'h11, 32'h10);
        `CHK(bus_u.tx_cnt, n0 + 1)
        wr(`HCC_ADDR_TEMP, 32'h00B0);
        `CHK(bus_u.tx_cnt, n0 + 2)
        `CHK(bus_u.tx_last, 1'b1)
        `CHK(cmd_out, 32'h40000000)
        `CHK(bus_u.nv_val, 1'b1)
        rdchk(`HCC_ADDR_COOBJ, 32'h1, 32'h1);
        $display("test auto done");
    endtask : t_auto

    task automatic t_cmd;
        wr(`HCC_ADDR_CTRL, 32'h52);
        wr(`HCC_ADDR_TEMP, 32'h00F0);
        n0 = bus_u.tx_cnt;
        wr(`HCC_ADDR_DEMAND, 32'h0050);
        `CHK(bus_u.tx_cnt, n0 + 1)
        `CHK(bus_u.tx_last, 1'b0)
        wr(`HCC_ADDR_TEMP, 32'h00D0);
        `CHK(bus_u.tx_cnt, n0 + 2)
        `CHK(bus_u.tx_last, 1'b0)
        $display("test command change done");
    endtask : t_cmd

    task automatic t_cycle;
        wr(`HCC_ADDR_CTRL, 32'h02);
        wr(`HCC_ADDR_CYCLE, 32'h02);
        n0 = bus_u.tx_cnt;
        cyc(80);
        `CHK(bus_u.tx_cnt - n0, 10)
        wr(`HCC_ADDR_CYCLE, 32'h00);
        n0 = bus_u.tx_cnt;
        cyc(40);
        `CHK(bus_u.tx_cnt, n0)
        wr(`HCC_ADDR_CTRL, 32'h40); // stores heating for the restart
        $display("test cyclic done");
    endtask : t_cycle

    task automatic t_obj;
        do_reset();
        wr(`HCC_ADDR_SETP, 32'h00DC00C8);
        wr(`HCC_ADDR_TEMP, 32'h00F0);
        wr(`HCC_ADDR_CTRL, 32'h4A);
        rdchk(`HCC_ADDR_STATUS, 32'h1, 32'h1);
        wr(`HCC_ADDR_COOBJ, 32'h0);
        rdchk(`HCC_ADDR_STATUS, 32'h1, 32'h0);
        wr(`HCC_ADDR_COOBJ, 32'h1);
        rdchk(`HCC_ADDR_STATUS, 32'h1, 32'h1);
        wr(`HCC_ADDR_CTRL, 32'h82);
        wr(`HCC_ADDR_TEMP, 32'h00F8);
        rdchk(`HCC_ADDR_STATUS, 32'h1, 32'h1);
        $display("test object control done");
    endtask : t_obj

    // main sequence
    initial
    begin
        srst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        @(posedge clk);
        do_reset();
        t_reset();
        t_single();
        t_auto();
        t_cmd();
        t_cycle();
        t_obj();
        stop_test();
    end
endmodule : testbench
